/* File: src/rsse_pkg.sv */
// =====================================================================
// shared constants and types
// =====================================================================
package rsse_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_LIT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MEM = 8'h20;

  // command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_IDX_LSB = 4;

  // status register fields (flags sit in bits 5:0)
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_SKIP_BIT = 9;

  // flag bit positions inside the flag byte
  localparam int FLG_CARRY = 0;
  localparam int FLG_ZERO = 1;
  localparam int FLG_HALF = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_SCMP = 4;
  localparam int FLG_CHAIN = 5;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] LIT_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic [5:0] FLG_RST = 6'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // instruction codes written to the command register
  typedef enum logic [2:0] {
    OP_ROT_RC_ACC = 3'h0, // rotate_right_thru_carry_to_accum
    OP_SUB_MEM = 3'h1, // subtract_borrow_to_accum, memory operand
    OP_SUB_IMM = 3'h2, // subtract_borrow_to_accum, literal operand
    OP_SUB_TO_MEM = 3'h3, // subtract_borrow_to_mem
    OP_DEC_SKIP = 3'h4, // decrement_skip_zero
    OP_DEC_ACC = 3'h5 // decrement_to_accum_skip_zero
  } rsse_op_t;

  // status flags, msb first so that bit n matches FLG_* above
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_cmp_flag;
    logic twos_complement_wrap_flag;
    logic half_carry_flag;
    logic zero;
    logic carry;
  } rsse_flags_t;

  // one register write as seen by the register file
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } rsse_wreq_t;

endpackage

/* File: src/rsse_sub_unit.sv */
`timescale 1ns/100ps
// =====================================================================
// 8-bit subtract with borrow and status flags
// =====================================================================
module rsse_sub_unit (
  // operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic carry_in,
  input wire logic chain_zero_in,
  // result
  output logic [7:0] diff,
  output rsse_pkg::rsse_flags_t flags
);
  import rsse_pkg::*;

  logic [8:0] full; // nine bits so the borrow is visible
  logic [4:0] low; // low nibble, for the half-carry borrow

  // difference is minuend - subtrahend - not(carry)
  always_comb
  begin
    full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carry_in};
    low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, ~carry_in};
    diff = full[7:0];
    // carry means no borrow, so it is set on a zero or positive result
    flags.carry = ~full[8];
    flags.half_carry_flag = ~low[4];
    flags.zero = (full[7:0] == 8'h00);
    // signed wrap: operands differ in sign and result sign left minuend's
    flags.twos_complement_wrap_flag = (minuend[7] ^ subtrahend[7]) & (full[7] ^ minuend[7]);
    // signed compare: set when the difference, corrected for wrap, is not negative
    flags.signed_cmp_flag = ~(full[7] ^ flags.twos_complement_wrap_flag);
    // chained zero stays set only while every byte of a chain was zero
    flags.chained_zero_flag = flags.zero & chain_zero_in;
  end

endmodule

/* File: src/rsse_axil_slave.sv */
`timescale 1ns/100ps
// =====================================================================
// axi4-lite slave front end
// =====================================================================
module rsse_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data channels
  input wire logic [rsse_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rsse_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [rsse_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rsse_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output logic wr_en,
  output rsse_pkg::rsse_wreq_t wr_req,
  input wire logic wr_err,
  output logic rd_en,
  output logic [rsse_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [rsse_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_err
);
  import rsse_pkg::*;

  logic aw_held_reg; // address taken, waiting for data
  logic w_held_reg; // data taken, waiting for address

  // take each write channel once, hold it until the response leaves
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_en = aw_held_reg & w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_en = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      wr_req.addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      wr_req.addr <= s_axi_awaddr;
    end
    else if (wr_en)
      aw_held_reg <= 1'b0;
  end

  // write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      wr_req.data <= '0;
      wr_req.strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wr_req.data <= s_axi_wdata;
      wr_req.strb <= s_axi_wstrb;
    end
    else if (wr_en)
      w_held_reg <= 1'b0;
  end

  // write response, one cycle after the register write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read data, registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_err ? '0 : rd_data;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

/* File: src/rsse_exec_top.sv */
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// =====================================================================
// How it works
// - rotate right: carry into bit7, bit0 out
// - rotate writes accumulator and carry, never memory
// - memory subtract: acc minus operand minus not-carry
// - literal subtract: acc minus literal minus not-carry
// - subtract-to-memory writes difference back to memory
// - carry clear on borrow, set otherwise
// - subtracts update all six status flags
// - decrement memory, skip on zero, flags untouched
// - decrement into accumulator, memory kept, skip zero
// - decrement-skip takes two cycles, dummy when skipped
// =====================================================================
// software loads accumulator, literal, flags and data bytes, then writes
// an instruction code to the command register; the block runs it and
// shows the outcome in the same registers.
module rsse_exec_top #(
  parameter int MEM_DEPTH = 4 // data bytes reachable by the index field
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [rsse_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rsse_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [rsse_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rsse_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // execution status towards the core
  output logic exec_busy,
  output logic skip_dummy
);
  import rsse_pkg::*;

  // =====================================================================
  // declarations
  // =====================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, // waiting for a command
    ST_EXEC = 3'b010, // first instruction cycle, results committed
    ST_DUMMY = 3'b100  // second cycle of a decrement-skip
  } rsse_state_t;

  localparam int IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  rsse_state_t state_reg; // sequencer state
  rsse_state_t state_next;
  rsse_op_t op_reg; // instruction being executed
  logic [IDX_W-1:0] idx_reg; // data byte addressed by it
  logic [7:0] acc_reg; // accumulator
  logic [7:0] lit_reg; // literal byte of the immediate form
  rsse_flags_t flags_reg; // status flags
  logic [7:0] mem_reg [MEM_DEPTH]; // data memory bytes
  logic skip_reg; // last instruction was a decrement that came out zero

  logic wr_en; // one register write this cycle
  rsse_wreq_t wr_req;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;

  logic cmd_go; // accepted command write
  logic [7:0] operand; // addressed data byte
  logic [7:0] sub_a; // subtractor inputs
  logic [7:0] sub_b;
  logic sub_cin;
  logic [7:0] sub_diff;
  rsse_flags_t sub_flags;
  logic [7:0] rot_val; // rotate result
  logic exec_now; // commit strobe

  // =====================================================================
  // helper functions
  // =====================================================================
  // any of the three subtract-with-borrow forms
  function automatic logic is_sub(input rsse_op_t op);
    return (op == OP_SUB_MEM) || (op == OP_SUB_IMM) || (op == OP_SUB_TO_MEM);
  endfunction

  // either decrement-and-skip form
  function automatic logic is_dec(input rsse_op_t op);
    return (op == OP_DEC_SKIP) || (op == OP_DEC_ACC);
  endfunction

  // true when an instruction code is one that this block knows
  function automatic logic op_known(input logic [2:0] code);
    return (code <= 3'(OP_DEC_ACC));
  endfunction

  // address falls in the data-byte window
  function automatic logic mem_hit(input logic [ADDR_W-1:0] addr);
    return (addr >= OFS_MEM) && (addr < 8'(OFS_MEM + 4 * MEM_DEPTH)) && (addr[1:0] == 2'b00);
  endfunction

  // data-byte index from a byte address
  function automatic logic [IDX_W-1:0] mem_idx(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFS_MEM;
    return IDX_W'(rel >> 2);
  endfunction

  // =====================================================================
  // bus front end
  // =====================================================================
  rsse_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_req(wr_req),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // =====================================================================
  // write decode
  // =====================================================================
  // writes while an instruction runs are refused so that software and
  // the datapath never fight over the same byte
  always_comb
  begin
    wr_err = 1'b0;
    cmd_go = 1'b0;
    if (state_reg != ST_IDLE)
      wr_err = 1'b1;
    else if (wr_req.addr == OFS_CMD)
    begin
      // unknown codes and an out-of-range index are refused
      if (!op_known(wr_req.data[CMD_OP_LSB +: 3]) || !wr_req.strb[0])
        wr_err = 1'b1;
      else if (32'(wr_req.data[CMD_IDX_LSB +: 4]) >= MEM_DEPTH)
        wr_err = 1'b1;
      else
        cmd_go = wr_en;
    end
    else if (wr_req.addr == OFS_ACC || wr_req.addr == OFS_LIT)
      wr_err = 1'b0;
    else if (wr_req.addr == OFS_STATUS)
      wr_err = 1'b0;
    else if (mem_hit(wr_req.addr))
      wr_err = 1'b0;
    else
      wr_err = 1'b1;
  end

  // =====================================================================
  // read decode
  // =====================================================================
  always_comb
  begin
    rd_data = '0;
    rd_err = 1'b0;
    if (rd_addr == OFS_CMD)
      rd_data = {24'h00_0000, 4'(idx_reg), 1'b0, op_reg};
    else if (rd_addr == OFS_ACC)
      rd_data = {24'h00_0000, acc_reg};
    else if (rd_addr == OFS_LIT)
      rd_data = {24'h00_0000, lit_reg};
    else if (rd_addr == OFS_STATUS)
    begin
      rd_data[5:0] = flags_reg;
      rd_data[ST_BUSY_BIT] = (state_reg != ST_IDLE);
      rd_data[ST_SKIP_BIT] = skip_reg;
    end
    else if (mem_hit(rd_addr))
      rd_data = {24'h00_0000, mem_reg[mem_idx(rd_addr)]};
    else
      rd_err = 1'b1;
  end

  // =====================================================================
  // datapath
  // =====================================================================
  assign operand = mem_reg[idx_reg];
  assign exec_now = (state_reg == ST_EXEC);

  assign rot_val = {flags_reg.carry, operand[7:1]};

  // subtractor operand selection
  always_comb
  begin
    sub_a = acc_reg;
    sub_b = operand;
    sub_cin = flags_reg.carry;
    if (op_reg == OP_SUB_IMM)
      sub_b = lit_reg;
    // decrement is operand - 0 - 1, with carry forced low
    else if (is_dec(op_reg))
    begin
      sub_a = operand;
      sub_b = 8'h00;
      sub_cin = 1'b0;
    end
  end

  // eight-bit subtract with the usual flag meanings
  rsse_sub_unit u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .carry_in(sub_cin),
    .chain_zero_in(flags_reg.chained_zero_flag),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // =====================================================================
  // sequencer
  // =====================================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (cmd_go)
          state_next = ST_EXEC;
      // decrement-skip always spends a second cycle
      ST_EXEC:
        state_next = is_dec(op_reg) ? ST_DUMMY : ST_IDLE;
      ST_DUMMY:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // command latch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_reg <= OP_ROT_RC_ACC;
      idx_reg <= '0;
    end
    else if (cmd_go)
    begin
      op_reg <= rsse_op_t'(wr_req.data[CMD_OP_LSB +: 3]);
      idx_reg <= IDX_W'(wr_req.data[CMD_IDX_LSB +: 4]);
    end
  end

  // skip outcome; the dummy marker stands for the whole second cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      skip_reg <= 1'b0;
      skip_dummy <= 1'b0;
    end
    else if (cmd_go)
      skip_reg <= 1'b0;
    // dummy instruction only when the skip is taken
    else if (exec_now && is_dec(op_reg))
    begin
      skip_reg <= (sub_diff == 8'h00);
      skip_dummy <= (sub_diff == 8'h00);
    end
    else
      skip_dummy <= 1'b0;
  end

  assign exec_busy = ~state_reg[0];

  // =====================================================================
  // accumulator
  // =====================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc_reg <= ACC_RST;
    else if (exec_now)
    begin
      // rotate result lands in the accumulator
      if (op_reg == OP_ROT_RC_ACC)
        acc_reg <= rot_val;
      else if (op_reg == OP_SUB_MEM || op_reg == OP_SUB_IMM)
        acc_reg <= sub_diff;
      else if (op_reg == OP_DEC_ACC)
        acc_reg <= sub_diff;
    end
    else if (wr_en && !wr_err && wr_req.addr == OFS_ACC && wr_req.strb[0])
      acc_reg <= wr_req.data[7:0];
  end

  // literal byte, software only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lit_reg <= LIT_RST;
    else if (wr_en && !wr_err && wr_req.addr == OFS_LIT && wr_req.strb[0])
      lit_reg <= wr_req.data[7:0];
  end

  // =====================================================================
  // status flags
  // =====================================================================
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_reg <= FLG_RST;
    else if (exec_now)
    begin
      // rotate touches only the carry among the flags
      if (op_reg == OP_ROT_RC_ACC)
        flags_reg.carry <= operand[0];
      // all six flags from the subtractor
      // carry there is the inverted borrow
      else if (is_sub(op_reg))
        flags_reg <= sub_flags;
    end
    else if (wr_en && !wr_err && wr_req.addr == OFS_STATUS && wr_req.strb[0])
      flags_reg <= wr_req.data[5:0];
  end

  // =====================================================================
  // data memory
  // =====================================================================
  // rotate and accumulator decrement never write here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem_reg[i] <= MEM_RST;
    end
    else if (exec_now && (op_reg == OP_SUB_TO_MEM || op_reg == OP_DEC_SKIP))
      mem_reg[idx_reg] <= sub_diff;
    else if (wr_en && !wr_err && mem_hit(wr_req.addr) && wr_req.strb[0])
      mem_reg[mem_idx(wr_req.addr)] <= wr_req.data[7:0];
  end

endmodule

/* File: sim/rsse_exec_props.sv */
`timescale 1ns/100ps
// =====================================================================
// port checker for the execution block
// =====================================================================
module rsse_exec_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // execution status
  input wire logic exec_busy,
  input wire logic skip_dummy
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_skip_busy; skip_dummy |-> exec_busy && $past(exec_busy); endproperty
  a_skip_busy: assert property (p_skip_busy) else $error("skip pulse outside busy");
  property p_skip_pulse; skip_dummy |=> !skip_dummy; endproperty
  a_skip_pulse: assert property (p_skip_pulse) else $error("skip pulse too long");
  property p_busy_max; exec_busy [*2] |=> !exec_busy; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy over two cycles");
  property p_busy_start; $rose(exec_busy) |-> $rose(s_axi_bvalid); endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy without command");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write response");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read data");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // main scenarios reached
  c_skip: cover property (skip_dummy);
  c_busy: cover property ($rose(exec_busy));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind rsse_exec_top rsse_exec_props rsse_exec_props_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .exec_busy,
  .skip_dummy);

/* File: sim/rsse_exec_top_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
// =====================================================================
// bench for the execution block
// =====================================================================
module rsse_exec_top_tb;
  import rsse_pkg::*;
  // stimulus, all quiet at time zero
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  // observed
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic exec_busy, skip_dummy;
  int num_errors = 0, checked = 0, n_skip = 0, n_busy = 0;
  rsse_exec_top #(.MEM_DEPTH(4)) rsse_exec_top_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_busy, .skip_dummy);
  // 100 ns clock
  initial
  begin
    forever #50 aclk = ~aclk;
  end
  // tally busy cycles and dummy pulses
  always @(posedge aclk)
  begin
    if (skip_dummy === 1'b1) n_skip++;
    if (exec_busy === 1'b1) n_busy++;
  end
  // =====================================================================
  // closing report
  // =====================================================================
  task automatic end_sim;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // =====================================================================
  // bus tasks, bounded waits
  // =====================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      // each channel released once taken
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) break;
      // late ready, so the response must stand a cycle
      if (s_axi_bvalid) s_axi_bready <= 1;
    end
    s_axi_bready <= 0;
    if (n == 50) begin num_errors++; end_sim(); end
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) break;
      // late ready, so the read data must stand a cycle
      if (s_axi_rvalid) s_axi_rready <= 1;
    end
    s_axi_rready <= 0;
    if (n == 50) begin num_errors++; end_sim(); end
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
  endtask
  // run one instruction and count its busy and dummy cycles
  task automatic run(input logic [2:0] op, input logic [3:0] idx, input int eb, input int es);
    int b0, s0;
    b0 = n_busy;
    s0 = n_skip;
    wr(OFS_CMD, {24'h0, idx, 1'b0, op}, RESP_OKAY);
    // busy has ended two cycles after the response
    repeat (3) @(posedge aclk);
    `CHK(n_busy - b0, eb)
    `CHK(n_skip - s0, es)
  endtask
  // =====================================================================
  // main sequence
  // =====================================================================
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(OFS_ACC, 0, RESP_OKAY);
    rd(OFS_STATUS, 0, RESP_OKAY);
    $display("test reset done");
    // rotate: carry into bit 7, bit 0 out, other flags kept
    wr(OFS_MEM, 32'h80, RESP_OKAY);
    wr(OFS_STATUS, 32'h3f, RESP_OKAY);
    run(OP_ROT_RC_ACC, 0, 1, 0);
    rd(OFS_ACC, 32'hc0, RESP_OKAY);
    rd(OFS_STATUS, 32'h3e, RESP_OKAY);
    rd(OFS_MEM, 32'h80, RESP_OKAY);
    $display("test rotate done");
    // memory subtract with borrow out
    wr(OFS_ACC, 32'h10, RESP_OKAY);
    wr(OFS_MEM + 8'h04, 32'h20, RESP_OKAY);
    wr(OFS_STATUS, 32'h01, RESP_OKAY);
    run(OP_SUB_MEM, 1, 1, 0);
    rd(OFS_ACC, 32'hf0, RESP_OKAY);
    rd(OFS_STATUS, 32'h04, RESP_OKAY);
    $display("test subtract memory done");
    // literal subtract wrapping past the sign
    wr(OFS_ACC, 32'h80, RESP_OKAY);
    wr(OFS_LIT, 32'h01, RESP_OKAY);
    wr(OFS_STATUS, 32'h01, RESP_OKAY);
    run(OP_SUB_IMM, 0, 1, 0);
    rd(OFS_ACC, 32'h7f, RESP_OKAY);
    rd(OFS_STATUS, 32'h09, RESP_OKAY);
    $display("test subtract literal done");
    // subtract to memory, zero result with borrow in
    wr(OFS_ACC, 32'h05, RESP_OKAY);
    wr(OFS_MEM + 8'h08, 32'h04, RESP_OKAY);
    wr(OFS_STATUS, 32'h20, RESP_OKAY);
    run(OP_SUB_TO_MEM, 2, 1, 0);
    rd(OFS_MEM + 8'h08, 32'h00, RESP_OKAY);
    rd(OFS_ACC, 32'h05, RESP_OKAY);
    rd(OFS_STATUS, 32'h37, RESP_OKAY);
    $display("test subtract to memory done");
    // decrement in memory: skip on zero, then wrap without skip
    wr(OFS_MEM + 8'h0c, 32'h01, RESP_OKAY);
    wr(OFS_STATUS, 32'h15, RESP_OKAY);
    run(OP_DEC_SKIP, 3, 2, 1);
    rd(OFS_MEM + 8'h0c, 32'h00, RESP_OKAY);
    rd(OFS_STATUS, 32'h215, RESP_OKAY);
    run(OP_DEC_SKIP, 3, 2, 0);
    rd(OFS_MEM + 8'h0c, 32'hff, RESP_OKAY);
    rd(OFS_STATUS, 32'h015, RESP_OKAY);
    $display("test decrement memory done");
    // decrement into accumulator, memory kept
    wr(OFS_ACC, 32'h33, RESP_OKAY);
    wr(OFS_MEM, 32'h01, RESP_OKAY);
    run(OP_DEC_ACC, 0, 2, 1);
    rd(OFS_ACC, 32'h00, RESP_OKAY);
    rd(OFS_MEM, 32'h01, RESP_OKAY);
    rd(OFS_STATUS, 32'h215, RESP_OKAY);
    $display("test decrement accumulator done");
    // refused accesses: unmapped, bad code, index past the end
    wr(8'h10, 32'h0, RESP_SLVERR);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(OFS_CMD, 32'h06, RESP_SLVERR);
    wr(OFS_CMD, 32'h44, RESP_SLVERR);
    rd(OFS_ACC, 32'h00, RESP_OKAY);
    $display("test refusals done");
    end_sim();
  end
endmodule
